// ===== dohm_pkg.sv
// display offset / horizontal scroll remap: shared constants and carrier types
// assumes one 100 MHz core clock; host command pins arrive asynchronously
package dohm_pkg;
    // command bytes and parameter limits
    localparam logic [7:0] DOHM_CMD_OFFSET = 8'hC8;
    localparam logic [7:0] DOHM_CMD_SCROLL = 8'hC9;
    localparam logic [7:0] DOHM_OFFSET_MAX = 8'h9F;
    // scan geometry
    localparam logic [8:0] DOHM_ROW_COUNT = 9'h0A0;
    localparam int DOHM_COL_BITS = 7;
    // reset values and synchroniser depth
    localparam logic [7:0] DOHM_RESET_OFFSET = 8'h00;
    localparam logic [6:0] DOHM_RESET_SCROLL = 7'h00;
    localparam int DOHM_SYNC_STAGES = 2;
    // field position of the scroll value inside its parameter byte
    localparam int DOHM_SCROLL_MSB = 6;

    typedef enum logic [1:0] {
        DOHM_IDLE,
        DOHM_WAIT_OFFSET,
        DOHM_WAIT_SCROLL
    } dohm_state_t;

    // host byte pins, raw
    typedef struct packed {
        logic dc;
        logic rd_n;
        logic wr_n;
        logic cs_n;
        logic [7:0] data;
    } dohm_host_t;

    // one scan position asked for by the timing generator
    typedef struct packed {
        logic valid;
        logic [7:0] row_line;
        logic [6:0] col_line;
    } dohm_scan_t;

    // remapped display frame ram address for that position
    typedef struct packed {
        logic valid;
        logic row_active;
        logic [7:0] ram_row;
        logic [6:0] ram_col;
    } dohm_map_t;

    typedef struct packed {
        dohm_host_t sync1;
        dohm_host_t sync2;
        logic wr_n_prev;
        dohm_state_t state;
        logic [7:0] offset;
        logic [6:0] scroll;
        dohm_map_t map;
    } dohm_regs_t;
endpackage : dohm_pkg

// ===== dohm_map.sv
// combinational remap from a row/column driver position to a frame ram address
// assumes offset + scanned row count stays within 160, as the host promises
`timescale 1ns/1ns
module dohm_map
    import dohm_pkg::*;
(
    // settings
    input wire logic [7:0] offset_i,
    input wire logic [6:0] scroll_i,
    input wire logic [8:0] scanned_row_count_i,
    // position in, address out
    input wire dohm_scan_t scan_i,
    output dohm_map_t map_o
);
    logic [8:0] row_sum;
    logic [8:0] row_wrapped;

    always_comb begin
        row_sum = {1'b0, scan_i.row_line} + {1'b0, offset_i};
        if (row_sum >= DOHM_ROW_COUNT) begin
            row_wrapped = row_sum - DOHM_ROW_COUNT;
        end else begin
            row_wrapped = row_sum;
        end
        map_o.valid = scan_i.valid;
        map_o.ram_row = row_wrapped[7:0];
        // lines whose ram row is beyond the scanned count stay dark
        map_o.row_active = scan_i.valid && (row_wrapped < scanned_row_count_i);
        // seven-bit add wraps modulo 128 by itself
        map_o.ram_col = scan_i.col_line + scroll_i;
    end
endmodule : dohm_map

// ===== dohm_core.sv
// display offset and horizontal scroll: command capture plus scan remap
// assumes host pins are asynchronous and held stable around the write strobe rise
// Notes on behaviour
// - command C8h then one parameter byte sets the offset, legal 00h to 9Fh.
// - offset maps the display start line onto one of row outputs 0 to 159.
// - offset N shifts the image N row lines toward row output zero.
// - rows beyond the scanned count show nothing; offset wraps rows to top lines.
// - command C9h then one parameter byte; low seven bits scroll, bit 7 ignored.
// - column output zero reads ram column equal to scroll; reset value 00h.
// - scroll n puts ram column n on column output zero, 7Fh gives column 127.
// - remaining column outputs take consecutive ram columns wrapping modulo 128.
`timescale 1ns/1ns
module dohm_core
    import dohm_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_i,
    // host command pins
    input wire dohm_host_t host_i,
    // scanned row count from the multiplex setting, same clock
    input wire logic [8:0] scanned_row_count_i,
    // scan request from the timing generator, same clock
    input wire dohm_scan_t scan_i,
    // remapped address toward display frame ram read-out
    output dohm_map_t map_o,
    // current settings
    output logic [7:0] offset_o,
    output logic [6:0] scroll_o
);
    dohm_regs_t state_reg;
    dohm_regs_t state_next;
    dohm_map_t map_comb;
    logic wr_rise;
    logic byte_ok;
    logic is_cmd;
    logic is_param;

    // remap reads the live settings; ram itself is never written here
    dohm_map u_map (
        .offset_i(state_reg.offset),
        .scroll_i(state_reg.scroll),
        .scanned_row_count_i(scanned_row_count_i),
        .scan_i(scan_i),
        .map_o(map_comb)
    );

    always_comb begin
        wr_rise = state_reg.wr_n_prev == 1'b0 && state_reg.sync2.wr_n == 1'b1;
        byte_ok = wr_rise && !state_reg.sync2.cs_n && state_reg.sync2.rd_n;
        is_cmd = byte_ok && !state_reg.sync2.dc;
        is_param = byte_ok && state_reg.sync2.dc;
    end

    always_comb begin
        state_next = state_reg;
        state_next.sync1 = host_i;
        state_next.sync2 = state_reg.sync1;
        state_next.wr_n_prev = state_reg.sync2.wr_n;
        state_next.map = map_comb;
        if (is_cmd) begin
            // any other command byte drops a pending parameter wait
            if (state_reg.sync2.data == DOHM_CMD_OFFSET) begin
                state_next.state = DOHM_WAIT_OFFSET;
            end else if (state_reg.sync2.data == DOHM_CMD_SCROLL) begin
                state_next.state = DOHM_WAIT_SCROLL;
            end else begin
                state_next.state = DOHM_IDLE;
            end
        end else if (is_param) begin
            unique case (state_reg.state)
                DOHM_WAIT_OFFSET: begin
                    // out of range offsets are dropped rather than mis-wrapped
                    if (state_reg.sync2.data <= DOHM_OFFSET_MAX) begin
                        state_next.offset = state_reg.sync2.data;
                    end
                    state_next.state = DOHM_IDLE;
                end
                DOHM_WAIT_SCROLL: begin
                    state_next.scroll = state_reg.sync2.data[DOHM_SCROLL_MSB:0];
                    state_next.state = DOHM_IDLE;
                end
                DOHM_IDLE: begin
                    state_next.state = DOHM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg.sync1 <= '{dc: 1'b0, rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, data: 8'h00};
            state_reg.sync2 <= '{dc: 1'b0, rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, data: 8'h00};
            state_reg.wr_n_prev <= 1'b1;
            state_reg.state <= DOHM_IDLE;
            state_reg.offset <= DOHM_RESET_OFFSET;
            state_reg.scroll <= DOHM_RESET_SCROLL;
            state_reg.map <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign map_o = state_reg.map;
    assign offset_o = state_reg.offset;
    assign scroll_o = state_reg.scroll;

    // checks
    a_offset_load: assert property (@(posedge clock_i) disable iff (reset_i)
        (is_param && state_reg.state == DOHM_WAIT_OFFSET && state_reg.sync2.data <= DOHM_OFFSET_MAX)
        |=> offset_o == $past(state_reg.sync2.data))
        else $error("offset parameter not loaded");
    a_offset_range: assert property (@(posedge clock_i) disable iff (reset_i)
        offset_o <= DOHM_OFFSET_MAX)
        else $error("offset beyond legal range");
    a_scroll_load: assert property (@(posedge clock_i) disable iff (reset_i)
        (is_param && state_reg.state == DOHM_WAIT_SCROLL)
        |=> scroll_o == $past(state_reg.sync2.data[6:0]))
        else $error("scroll parameter not loaded");
    a_param_single: assert property (@(posedge clock_i) disable iff (reset_i)
        (is_param && state_reg.state != DOHM_IDLE) |=> state_reg.state == DOHM_IDLE)
        else $error("second parameter accepted");
    a_idle_param: assert property (@(posedge clock_i) disable iff (reset_i)
        (is_param && state_reg.state == DOHM_IDLE) |=> $stable(offset_o) && $stable(scroll_o))
        else $error("stray parameter changed a setting");
    // the map register samples the setting of the cycle before, so compare against that one
    a_row_remap: assert property (@(posedge clock_i) disable iff (reset_i)
        (scan_i.valid && $stable(offset_o)) |=> map_o.valid
        && ({1'b0, map_o.ram_row}
        == (({1'b0, $past(scan_i.row_line)} + {1'b0, $past(offset_o)}) % DOHM_ROW_COUNT)))
        else $error("row remap wrong");
    a_col_wrap: assert property (@(posedge clock_i) disable iff (reset_i)
        (scan_i.valid && $stable(scroll_o))
        |=> map_o.ram_col == 7'($past(scan_i.col_line) + $past(scroll_o)))
        else $error("column remap wrong");
    a_row_blank: assert property (@(posedge clock_i) disable iff (reset_i)
        map_o.row_active |-> ({1'b0, map_o.ram_row} < DOHM_ROW_COUNT) && map_o.valid)
        else $error("row active out of range");
    a_cmd_wait: assert property (@(posedge clock_i) disable iff (reset_i)
        (is_cmd && state_reg.sync2.data == DOHM_CMD_SCROLL) |=> state_reg.state == DOHM_WAIT_SCROLL)
        else $error("scroll command not decoded");
    a_offset_cmd: assert property (@(posedge clock_i) disable iff (reset_i)
        (is_cmd && state_reg.sync2.data == DOHM_CMD_OFFSET) |=> state_reg.state == DOHM_WAIT_OFFSET)
        else $error("offset command not decoded");
    a_offset_drop: assert property (@(posedge clock_i) disable iff (reset_i)
        (is_param && state_reg.state == DOHM_WAIT_OFFSET && state_reg.sync2.data > DOHM_OFFSET_MAX)
        |=> $stable(offset_o) && state_reg.state == DOHM_IDLE)
        else $error("out of range offset taken");
    a_cmd_other: assert property (@(posedge clock_i) disable iff (reset_i)
        (is_cmd && state_reg.sync2.data != DOHM_CMD_OFFSET && state_reg.sync2.data != DOHM_CMD_SCROLL)
        |=> state_reg.state == DOHM_IDLE)
        else $error("foreign command kept a wait");
    a_cmd_settings: assert property (@(posedge clock_i) disable iff (reset_i)
        is_cmd |=> $stable(offset_o) && $stable(scroll_o))
        else $error("command byte changed a setting");
    a_strobe_refused: assert property (@(posedge clock_i) disable iff (reset_i)
        (wr_rise && !byte_ok) |=> $stable(state_reg.state) && $stable(offset_o) && $stable(scroll_o))
        else $error("refused strobe had an effect");
    a_map_valid: assert property (@(posedge clock_i) disable iff (reset_i)
        1'b1 |=> map_o.valid == $past(scan_i.valid))
        else $error("map valid does not follow scan");
    a_row_lit: assert property (@(posedge clock_i) disable iff (reset_i)
        scan_i.valid |=> map_o.row_active == ({1'b0, map_o.ram_row} < $past(scanned_row_count_i)))
        else $error("row lit state wrong");
    c_offset_set: cover property (@(posedge clock_i) disable iff (reset_i)
        is_param && state_reg.state == DOHM_WAIT_OFFSET);
    c_scroll_set: cover property (@(posedge clock_i) disable iff (reset_i)
        is_param && state_reg.state == DOHM_WAIT_SCROLL);
    c_row_dark: cover property (@(posedge clock_i) disable iff (reset_i)
        map_o.valid && !map_o.row_active);
    c_cmd_drop: cover property (@(posedge clock_i) disable iff (reset_i)
        is_cmd && state_reg.state != DOHM_IDLE && state_reg.sync2.data != DOHM_CMD_OFFSET
        && state_reg.sync2.data != DOHM_CMD_SCROLL);
    c_refused: cover property (@(posedge clock_i) disable iff (reset_i)
        wr_rise && !byte_ok);
endmodule : dohm_core

// ===== dohm_host_model.sv
// host-side model: drives command and parameter bytes onto the host pins
// assumes the bench calls put_byte at a falling edge of clock_i
`timescale 1ns/1ns
module dohm_host_model
    import dohm_pkg::*;
(
    input wire logic clock_i,
    output dohm_host_t host_o
);
    // raised by the bench to make a write that the core must refuse
    logic read_strobe = 1'b0;

    initial host_o = '{dc: 1'b1, rd_n: 1'b1, wr_n: 1'b1, cs_n: 1'b1, data: 8'hA5};

    // strobe phases of four clocks clear the three-clock synchroniser margin
    task automatic put_byte(input logic dc, input logic [7:0] data, input logic sel);
        @(negedge clock_i);
        host_o.cs_n = ~sel;
        host_o.dc = dc;
        host_o.rd_n = ~read_strobe;
        host_o.data = data;
        host_o.wr_n = 1'b0;
        repeat (4) @(negedge clock_i);
        host_o.wr_n = 1'b1;
        repeat (4) @(negedge clock_i);
        host_o.cs_n = 1'b1;
        // released bus must not keep its last value
        host_o.data = ~data;
    endtask : put_byte
endmodule : dohm_host_model

// ===== tb_display_offset_hscroll_map.sv
// self-checking bench for the offset / scroll remap core
// assumes dohm_host_model drives the host pins; scan and row count driven here
`timescale 1ns/1ns
module tb_display_offset_hscroll_map;
    import dohm_pkg::*;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic [8:0] count = 9'h0A0;
    dohm_scan_t scan = '0;
    dohm_host_t host;
    dohm_map_t map;
    logic [7:0] offset;
    logic [6:0] scroll;
    logic [7:0] exp_off = 8'h00;
    logic [6:0] exp_scr = 7'h00;
    logic [7:0] tab [6] = '{8'h00, 8'h82, 8'h04, 8'hFF, 8'hFD, 8'h7B};
    int error_cnt = 0;
    int samples_checked = 0;

    always #5 clock_i = ~clock_i;

    dohm_host_model i_dohm_host_model (.clock_i(clock_i), .host_o(host));
    dohm_core i_dohm_core (.clock_i(clock_i), .reset_i(reset_i), .host_i(host), .scanned_row_count_i(count),
        .scan_i(scan), .map_o(map), .offset_o(offset), .scroll_o(scroll));

    function automatic dohm_map_t exp_map(input logic [7:0] row, input logic [6:0] col);
        logic [8:0] r;
        r = (9'(row) + 9'(exp_off)) % DOHM_ROW_COUNT;
        exp_map = '{valid: 1'b1, row_active: r < count, ram_row: r[7:0], ram_col: col + exp_scr};
    endfunction : exp_map

    task automatic chk(input logic [23:0] got, input logic [23:0] want);
        samples_checked++;
        if (got !== want) begin
            error_cnt++;
            $display("Error at %0t: got %h want %h", $time, got, want);
        end
    endtask : chk

    // called at a falling edge; successive calls give back-to-back samples
    task automatic probe(input logic [7:0] row, input logic [6:0] col);
        scan = '{valid: 1'b1, row_line: row, col_line: col};
        @(negedge clock_i);
        chk(24'(map), 24'(exp_map(row, col)));
    endtask : probe

    task automatic set_val(input logic [7:0] cmd, input logic [7:0] val, input logic sel);
        logic take;
        take = sel && !i_dohm_host_model.read_strobe;
        i_dohm_host_model.put_byte(1'b0, cmd, sel);
        i_dohm_host_model.put_byte(1'b1, val, sel);
        repeat (2) @(negedge clock_i);
        if (take && cmd == DOHM_CMD_SCROLL) exp_scr = val[6:0];
        if (take && cmd == DOHM_CMD_OFFSET && val <= DOHM_OFFSET_MAX) exp_off = val;
        chk(24'(offset), 24'(exp_off));
        chk(24'(scroll), 24'(exp_scr));
    endtask : set_val

    task automatic final_report;
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        #400000;
        error_cnt++;
        final_report;
    end

    initial begin
        void'($urandom(8));
        repeat (16) @(negedge clock_i);
        reset_i = 1'b0;
        chk(24'(map), 24'h0);
        chk(24'({offset, scroll}), 24'h0);
        probe(8'h00, 7'h00);
        foreach (tab[k]) begin
            set_val(DOHM_CMD_SCROLL, tab[k], 1'b1);
            probe(8'h00, 7'h00);
            probe(8'h03, 7'h7E);
            probe(8'h9F, 7'h7F);
        end
        for (int n = 1; n < 128; n++) set_val(DOHM_CMD_SCROLL, 8'(n), 1'b1);
        $display("test scroll done");
        count = 9'h090;
        set_val(DOHM_CMD_OFFSET, 8'h10, 1'b1);
        probe(8'h00, 7'h00);
        count = 9'h060;
        set_val(DOHM_CMD_OFFSET, 8'h20, 1'b1);
        foreach (tab[k]) probe(tab[k] + 8'h1F, 7'h01);
        probe(8'h80, 7'h02);
        count = 9'h001;
        set_val(DOHM_CMD_OFFSET, 8'h9F, 1'b1);
        probe(8'h00, 7'h00);
        probe(8'h01, 7'h00);
        set_val(DOHM_CMD_OFFSET, 8'hA0, 1'b1);
        set_val(DOHM_CMD_SCROLL, 8'h33, 1'b0);
        i_dohm_host_model.put_byte(1'b0, DOHM_CMD_OFFSET, 1'b1);
        set_val(8'hAF, 8'h05, 1'b1);
        i_dohm_host_model.read_strobe = 1'b1;
        set_val(DOHM_CMD_OFFSET, 8'h11, 1'b1);
        i_dohm_host_model.read_strobe = 1'b0;
        $display("test offset done");
        repeat (20) begin
            count = 9'h001;
            exp_off = 8'($urandom_range(0, 158));
            set_val(DOHM_CMD_OFFSET, exp_off, 1'b1);
            count = 9'($urandom_range(1, 159 - exp_off));
            set_val(DOHM_CMD_SCROLL, 8'($urandom), 1'b1);
            repeat (4) probe(8'($urandom_range(0, 159)), 7'($urandom));
        end
        $display("test random done");
        set_val(DOHM_CMD_SCROLL, 8'h41, 1'b1);
        reset_i = 1'b1;
        repeat (3) @(negedge clock_i);
        reset_i = 1'b0;
        exp_off = DOHM_RESET_OFFSET;
        exp_scr = DOHM_RESET_SCROLL;
        chk(24'({offset, scroll}), 24'({exp_off, exp_scr}));
        probe(8'h05, 7'h09);
        set_val(DOHM_CMD_SCROLL, 8'h06, 1'b1);
        probe(8'h07, 7'h7C);
        $display("test reset done");
        final_report;
    end
endmodule : tb_display_offset_hscroll_map
